// ==== spgate_sync.sv ====
`timescale 1ns/100ps

//==========================================================
// shared constants and types
package spgate_pkg;

    // instruction codes
    localparam logic [7:0] OP_SET_WE    = 8'h06;
    localparam logic [7:0] OP_CLR_WE    = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_WRITE     = 8'h02;

    // frame geometry
    localparam logic [2:0] LAST_BIT        = 3'h7;
    localparam logic [2:0] BIT_FIRST       = 3'h0;
    localparam logic [2:0] BYTES_NONE      = 3'h0;
    localparam logic [2:0] BYTES_SAT       = 3'h4;
    localparam logic [2:0] CMD_BYTES       = 3'h1;
    localparam logic [2:0] WR_STATUS_BYTES = 3'h2;
    localparam logic [2:0] WRITE_MIN_BYTES = 3'h4;

    // status byte as shifted out
    localparam int         STATUS_BUSY_BIT = 0;
    localparam int         STATUS_LATCH_BIT = 1;
    localparam logic [7:0] STATUS_CLEAR    = 8'h00;
    localparam logic [7:0] STATUS_BUSY     = 8'hFF;

    // self-timed write cycle
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 5000;
    localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_STANDBY,
        ST_WRITING
    } spgate_state_type;

    // what the link saw in the latest frame
    typedef struct packed {
        logic [7:0] opcode;
        logic [2:0] bytes;
        logic       partial;
    } spgate_frame_type;

    typedef struct packed {
        logic latch;
        logic busy;
    } spgate_status_type;

endpackage

//==========================================================
// three-stage synchroniser, output moves once stages 2 and 3 agree
module spgate_sync
    import spgate_pkg::*;
#(
    parameter int         WIDTH     = 1,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= RESET_VAL[WIDTH-1:0];
            s2_q  <= RESET_VAL[WIDTH-1:0];
            s3_q  <= RESET_VAL[WIDTH-1:0];
            out_q <= RESET_VAL[WIDTH-1:0];
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule

// ==== spgate_core.sv ====
// How it works
// - releasing the power-on reset moves the block from reset into standby.
// - asserting the power-on reset returns to reset and drops any command in flight.
// - the write-enable latch comes out of reset cleared, write disabled.
// - an instruction other than read-status counts only in a frame whose select fall was seen after power-up.
// - the latch clears itself when a write cycle completes.
// - the internal write starts on select rising after a whole write frame: four bytes or more for write, exactly two for write-status.
// - array accesses during a write cycle are ignored and programming runs on.
// - an unknown opcode does nothing and the serial output stays undriven.
// - during a write cycle only the read-status instruction is serviced.
// - busy reads as one for the whole write cycle and zero once ready.
// - set-write-enable sets the latch, clear-write-enable clears it.
`timescale 1ns/100ps

module spgate_core
    import spgate_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    // core clock and power-on reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // serial link
    input  wire logic sck,
    input  wire logic chipSel_n,
    input  wire logic sdi,
    output logic      sdo,
    output logic      sdoEn,
    // status towards array logic
    output logic      writeBusy,
    output logic      write_enable_latch,
    output logic      inStandby,
    output logic      programStart
);
    //==========================================================
    // link domain: opcode capture and frame summary
    logic             linkRst_n;
    logic [2:0]       bitIdx_q, bitIdx_d;
    logic [2:0]       bytes_q, bytes_d;
    logic [7:0]       op_q, op_d;
    spgate_frame_type sum_q, sum_d;
    logic             tag_q, tag_d;
    logic             soEn_q, soEn_d;
    logic             so_q, so_d;
    logic [7:0]       statusByte;
    spgate_status_type linkStatus;
    spgate_status_type coreStatus;

    // select high clears the shifter; the summary survives for the core
    assign linkRst_n = reset_n & ~chipSel_n;

    always_comb begin
        bitIdx_d = bitIdx_q + 3'h1;
        bytes_d  = bytes_q;
        if (bitIdx_q == LAST_BIT && bytes_q != BYTES_SAT) begin
            bytes_d = bytes_q + 3'h1;
        end
        op_d = (bytes_q == BYTES_NONE) ? {op_q[6:0], sdi} : op_q;
        sum_d.opcode  = op_d;
        sum_d.bytes   = bytes_d;
        sum_d.partial = (bitIdx_d != BIT_FIRST);
        // a fresh tag per frame so the core never acts twice on one summary
        tag_d = (bitIdx_q == BIT_FIRST && bytes_q == BYTES_NONE) ? ~tag_q : tag_q;
    end

    always_ff @(posedge sck or negedge linkRst_n) begin
        if (!linkRst_n) begin
            bitIdx_q <= BIT_FIRST;
            bytes_q  <= BYTES_NONE;
            op_q     <= STATUS_CLEAR;
        end else begin
            bitIdx_q <= bitIdx_d;
            bytes_q  <= bytes_d;
            op_q     <= op_d;
        end
    end

    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            sum_q <= '0;
            tag_q <= 1'b0;
        end else begin
            sum_q <= sum_d;
            tag_q <= tag_d;
        end
    end

    spgate_sync #(.WIDTH(2), .RESET_VAL(8'h00)) u_statusSync (
        .clk   (sck),
        .rst_n (reset_n),
        .din   (coreStatus),
        .dout  (linkStatus)
    );

    // busy forces an all-ones status byte
    assign statusByte = linkStatus.busy ? STATUS_BUSY :
        (STATUS_CLEAR | ({7'h00, linkStatus.latch} << STATUS_LATCH_BIT));

    always_comb begin
        soEn_d = 1'b0;
        so_d   = 1'b0;
        // only read-status drives; unknown opcodes leave the pin floating
        if (bytes_q != BYTES_NONE && op_q == OP_RD_STATUS) begin
            soEn_d = 1'b1;
            so_d   = statusByte[LAST_BIT - bitIdx_q];
        end
    end

    always_ff @(negedge sck or negedge linkRst_n) begin
        if (!linkRst_n) begin
            soEn_q <= 1'b0;
            so_q   <= 1'b0;
        end else begin
            soEn_q <= soEn_d;
            so_q   <= so_d;
        end
    end

    assign sdo   = so_q;
    assign sdoEn = soEn_q;

    //==========================================================
    // core domain: power state, latch, write timer
    spgate_state_type state_q, state_d;
    logic             csLevel, csPrev_q, csPrev_d;
    logic             tagSync;
    logic             used_q, used_d;
    logic             armed_q, armed_d;
    logic             latch_q, latch_d;
    logic             busy_q, busy_d;
    logic             standby_q, standby_d;
    logic             start_q, start_d;
    logic [31:0]      timer_q, timer_d;
    logic             csRise, csFall, accept, opKnown, whole;

    // reset value low: a select held low through power-up never counts as a fall
    spgate_sync #(.WIDTH(1), .RESET_VAL(8'h00)) u_csSync (
        .clk   (core_clk),
        .rst_n (reset_n),
        .din   (chipSel_n),
        .dout  (csLevel)
    );

    spgate_sync #(.WIDTH(1), .RESET_VAL(8'h00)) u_tagSync (
        .clk   (core_clk),
        .rst_n (reset_n),
        .din   (tag_q),
        .dout  (tagSync)
    );

    assign csRise  = csLevel & ~csPrev_q;
    assign csFall  = ~csLevel & csPrev_q;
    assign accept  = csRise & armed_q & (tagSync != used_q);
    assign whole   = ~sum_q.partial;
    assign opKnown = sum_q.opcode inside {OP_SET_WE, OP_CLR_WE, OP_RD_STATUS,
                                          OP_WR_STATUS, OP_READ, OP_WRITE};

    always_comb begin
        state_d  = state_q;
        csPrev_d = csLevel;
        // every select rise consumes the frame's tag, taken or not
        used_d   = csRise ? tagSync : used_q;
        armed_d  = armed_q;
        latch_d  = latch_q;
        timer_d  = timer_q;
        start_d  = 1'b0;
        if (csFall && state_q != ST_RESET) begin
            armed_d = 1'b1;
        end
        case (state_q)
            ST_RESET: begin
                state_d = ST_STANDBY;
                latch_d = 1'b0;
            end
            ST_STANDBY: begin
                if (accept && opKnown && whole) begin
                    if (sum_q.opcode == OP_SET_WE && sum_q.bytes == CMD_BYTES) begin
                        latch_d = 1'b1;
                    end else if (sum_q.opcode == OP_CLR_WE && sum_q.bytes == CMD_BYTES) begin
                        latch_d = 1'b0;
                    end else if (latch_q && ((sum_q.opcode == OP_WRITE &&
                                 sum_q.bytes >= WRITE_MIN_BYTES) ||
                                 (sum_q.opcode == OP_WR_STATUS &&
                                 sum_q.bytes == WR_STATUS_BYTES))) begin
                        state_d = ST_WRITING;
                        start_d = 1'b1;
                        timer_d = WRITE_CYCLES_P - 1;
                    end
                end
            end
            ST_WRITING: begin
                // frames accepted here are dropped without effect
                if (timer_q == 32'h0) begin
                    state_d = ST_STANDBY;
                    latch_d = 1'b0;
                end else begin
                    timer_d = timer_q - 32'h1;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        busy_d    = (state_d == ST_WRITING);
        standby_d = (state_d == ST_STANDBY);
    end

    // power-on reset drops everything in flight
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= ST_RESET;
            csPrev_q  <= 1'b0;
            used_q    <= 1'b0;
            armed_q   <= 1'b0;
            latch_q   <= 1'b0;
            busy_q    <= 1'b0;
            standby_q <= 1'b0;
            start_q   <= 1'b0;
            timer_q   <= 32'h0;
        end else begin
            state_q   <= state_d;
            csPrev_q  <= csPrev_d;
            used_q    <= used_d;
            armed_q   <= armed_d;
            latch_q   <= latch_d;
            busy_q    <= busy_d;
            standby_q <= standby_d;
            start_q   <= start_d;
            timer_q   <= timer_d;
        end
    end

    assign coreStatus.latch = latch_q;
    assign coreStatus.busy  = busy_q;

    assign writeBusy          = busy_q;
    assign write_enable_latch = latch_q;
    assign inStandby          = standby_q;
    assign programStart       = start_q;
endmodule

// ==== spgate_core_props.sv ====
`timescale 1ns/100ps
//==========
// checker on the core ports
module spgate_core_props
    import spgate_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // serial link
    input wire logic sck,
    input wire logic chipSel_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdoEn,
    // status
    input wire logic writeBusy,
    input wire logic write_enable_latch,
    input wire logic inStandby,
    input wire logic programStart
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    int busyCnt_q;
    int busyCnt_d;
    always_comb busyCnt_d = writeBusy ? busyCnt_q + 1 : 0;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) busyCnt_q <= 0;
        else busyCnt_q <= busyCnt_d;
    end
    sequence s_launch;
        programStart && writeBusy && !inStandby;
    endsequence
    AST_BUSY_CAUSE: assert property ($rose(writeBusy) |-> s_launch)
        else $error("busy rose without a start");
    // busy spans exactly the timer's count, reload value down to zero
    AST_BUSY_LEN: assert property ($fell(writeBusy) |-> busyCnt_q == WRITE_CYCLES_P)
        else $error("write cycle length wrong");
    AST_LATCH_END: assert property ($fell(writeBusy) |-> !write_enable_latch)
        else $error("latch still set after write");
    AST_START_OK: assert property (programStart |-> $past(write_enable_latch) && !$past(writeBusy))
        else $error("write started while refused");
    AST_PULSE: assert property (programStart |=> !programStart)
        else $error("start longer than one cycle");
    AST_STANDBY: assert property (inStandby |-> !writeBusy)
        else $error("standby while busy");
    AST_LEAVE: assert property ($fell(inStandby) |-> s_launch)
        else $error("standby left without a write");
    AST_SDO_OFF: assert property (chipSel_n |-> !sdoEn)
        else $error("output driven while deselected");
    AST_LATCH_SET: assert property ($rose(write_enable_latch) |-> chipSel_n && !writeBusy)
        else $error("latch set at wrong moment");
endmodule
bind spgate_core spgate_core_props #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) i_props (
    .core_clk(core_clk), .reset_n(reset_n), .sck(sck), .chipSel_n(chipSel_n), .sdi(sdi),
    .sdo(sdo), .sdoEn(sdoEn), .writeBusy(writeBusy), .write_enable_latch(write_enable_latch),
    .inStandby(inStandby), .programStart(programStart));

// ==== spgate_host.sv ====
`timescale 1ns/100ps
//==========
// host model, mode 0, clock still between frames
module spgate_host (
    // link out
    output logic      sck,
    output logic      chipSel_n,
    output logic      sdi,
    // link in
    input  wire logic sdo,
    input  wire logic sdoEn
);
    logic [7:0] rxByte;
    logic       sawDrive;
    // select low through power-up, so the first frame has no fall
    initial begin
        sck = 1'b0;
        chipSel_n = 1'b0;
        sdi = 1'b0;
    end
    // whole bytes only, msb first, top byte first
    task automatic frame(input logic [31:0] data, input int n);
        sawDrive = 1'b0;
        chipSel_n <= 1'b0;
        #10;
        for (int i = 0; i < 8 * n; i++) begin
            sdi <= data[31-i];
            #7.5 sck <= 1'b1;
            // no pull on the line: an undriven output reads inverted
            rxByte = {rxByte[6:0], sdoEn ? sdo : ~sdo};
            if (sdoEn) sawDrive = 1'b1;
            #7.5 sck <= 1'b0;
        end
        #7.5 chipSel_n <= 1'b1;
        sdi <= ~sdi;
        #100;
    endtask
endmodule

// ==== tb_spgate_core.sv ====
`timescale 1ns/100ps
//==========
// bench
module tb_spgate_core
    import spgate_pkg::*;
;
    logic core_clk, reset_n, sck, chipSel_n, sdi, sdo, sdoEn;
    logic writeBusy, latch, inStandby, programStart;
    logic [7:0] op;
    int failures, compares;
    always #5 core_clk = ~core_clk;
    spgate_core #(.WRITE_CYCLES_P(200)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .sck(sck), .chipSel_n(chipSel_n), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn),
        .writeBusy(writeBusy), .write_enable_latch(latch), .inStandby(inStandby),
        .programStart(programStart));
    spgate_host i_host (.sck(sck), .chipSel_n(chipSel_n), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn));
    task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] status_exp(input logic busy, input logic w);
        return busy ? STATUS_BUSY : 8'(w) << STATUS_LATCH_BIT;
    endfunction
    task state(input logic b, input logic w, input logic s);
        cmp("busy", 8'(b), 8'(writeBusy));
        cmp("latch", 8'(w), 8'(latch));
        cmp("standby", 8'(s), 8'(inStandby));
    endtask
    task final_report;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cmd(input logic [7:0] c, input int n);
        i_host.frame({c, 24'($urandom)}, n);
    endtask
    initial begin
        #500us;
        failures++;
        final_report();
    end
    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        void'($urandom(32'h235E));
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        state(0, 0, 1);
        cmd(OP_SET_WE, 1);
        state(0, 0, 1);
        cmd(OP_SET_WE, 1);
        state(0, 1, 1);
        cmd(OP_RD_STATUS, 3);
        cmp("status", status_exp(0, 1), i_host.rxByte);
        cmd(OP_CLR_WE, 1);
        state(0, 0, 1);
        cmd(OP_WRITE, 4);
        state(0, 0, 1);
        for (int k = 0; k < 2; k++) begin
            cmd(OP_SET_WE, 1);
            cmd(k ? OP_WR_STATUS : OP_WRITE, k ? 2 : 4);
            state(1, 1, 0);
            cmd(OP_RD_STATUS, 3);
            cmp("status", status_exp(1, 1), i_host.rxByte);
            cmd(OP_WRITE, 4);
            state(1, 1, 0);
            cmd(OP_CLR_WE, 1);
            state(1, 1, 0);
            for (int i = 0; i < 400 && writeBusy !== 1'b0; i++) @(posedge core_clk);
            if (writeBusy !== 1'b0) begin
                failures++;
                final_report();
            end
            #1;
            state(0, 0, 1);
        end
        cmd(OP_SET_WE, 1);
        cmd(OP_READ, 3);
        state(0, 1, 1);
        repeat (6) begin
            op = 8'($urandom);
            if (op inside {OP_SET_WE, OP_CLR_WE, OP_RD_STATUS, OP_WR_STATUS, OP_READ, OP_WRITE})
                op = 8'hA5;
            cmd(op, 2);
            cmp("drive", 8'h00, 8'(i_host.sawDrive));
            state(0, 1, 1);
        end
        // power loss in the middle of a write cycle
        cmd(OP_WRITE, 4);
        state(1, 1, 0);
        @(posedge core_clk);
        reset_n <= 1'b0;
        @(posedge core_clk);
        #1;
        state(0, 0, 0);
        @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        state(0, 0, 1);
        final_report();
    end
endmodule
